// ==== rtl/pattern_slice.sv ====
// one pattern slice: level or edge test with sticky edge memory
`timescale 1ns/100ps
module pattern_slice
   import pint_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              lvl,
   input  wire logic              rise,
   input  wire logic              fall,
   input  wire logic [COND_W-1:0] cond,
   input  wire logic              clear,
   output logic                   hit
);
   logic rise_seen;
   logic fall_seen;

   // ----------------------------------------
   // sticky edges, set wins over clear
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         rise_seen <= 1'b0;
         fall_seen <= 1'b0;
      end else begin
         rise_seen <= (rise_seen & ~clear) | rise;
         fall_seen <= (fall_seen & ~clear) | fall;
      end
   end

   // ----------------------------------------
   // condition
   // ----------------------------------------
   always_comb begin
      case (cond_t'(cond))
         COND_ALWAYS:   hit = 1'b1;
         COND_RISE_ST:  hit = rise_seen | rise;
         COND_FALL_ST:  hit = fall_seen | fall;
         COND_EDGE_ST:  hit = rise_seen | fall_seen | rise | fall;
         COND_HIGH:     hit = lvl;
         COND_LOW:      hit = ~lvl;
         COND_NEVER:    hit = 1'b0;
         COND_EDGE_NOW: hit = rise | fall;
         default:       hit = 1'b0;
      endcase
   end
endmodule

// ==== rtl/pin_interrupt_pattern_match.sv ====
// pin interrupt and pattern match engine with its register port
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
module pin_interrupt_pattern_match
   import pint_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic [N_PINS-1:0] PINS,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [DATA_W-1:0] RDATA,
   output logic      [N_CH-1:0]   IRQ,
   output logic                   WAKE_REQ,
   output logic                   CPU_EVENT_NOTIFY,
   output logic                   PATTERN_MATCH_PIN_OUT
);
   // ----------------------------------------
   // configuration state
   // ----------------------------------------
   logic [DATA_W-1:0]       sel_lo;
   logic [DATA_W-1:0]       sel_hi;
   logic [N_CH-1:0]         mode_level;
   logic [N_CH-1:0]         en_rise;
   logic [N_CH-1:0]         en_fall;
   logic [N_CH-1:0]         rise_st;
   logic [N_CH-1:0]         fall_st;
   logic                    pm_on;
   logic                    ev_en;
   logic [N_CH*SRC_W-1:0]   pm_src;
   logic [N_CH-1:0]         endpoint;
   logic [N_CH*COND_W-1:0]  pm_cond;
   logic [N_CH-1:0]         wake_en;
   logic                    cfg_clear;

   // ----------------------------------------
   // datapath signals
   // ----------------------------------------
   logic [N_CH-1:0]         lvl;
   logic [N_CH-1:0]         rise;
   logic [N_CH-1:0]         fall;
   logic [N_CH-1:0]         slice_hit;
   logic [N_CH-1:0]         term;
   logic [N_CH-1:0]         pin_req;
   logic [N_CH-1:0]         next_irq;
   logic                    any_match;
   logic                    match_prev;
   logic [DATA_W-1:0]       next_rdata;

   // ----------------------------------------
   // per channel pin select, sync and slice
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         logic [SEL_W-1:0] sel;
         logic [SRC_W-1:0] src;
         if (g < SEL_PER_REG) begin : g_lo
            assign sel = sel_lo[g*SEL_STRIDE +: SEL_W];
         end else begin : g_hi
            assign sel = sel_hi[(g-SEL_PER_REG)*SEL_STRIDE +: SEL_W];
         end
         assign src = pm_src[g*SRC_W +: SRC_W];

         pin_sync_edge u_sync (
            .CLK  (CLK),
            .RST  (RST),
            .pin  (PINS[sel]),
            .lvl  (lvl[g]),
            .rise (rise[g]),
            .fall (fall[g])
         );

         pattern_slice u_slice (
            .CLK   (CLK),
            .RST   (RST),
            .lvl   (lvl[src]),
            .rise  (rise[src]),
            .fall  (fall[src]),
            .cond  (pm_cond[g*COND_W +: COND_W]),
            .clear (cfg_clear),
            .hit   (slice_hit[g])
         );

         // level request: enable in en_rise, polarity in en_fall
         assign pin_req[g] = mode_level[g]
                           ? (en_rise[g] & (lvl[g] == en_fall[g]))
                           : (rise_st[g] | fall_st[g]);
      end
   endgenerate

   // ----------------------------------------
   // product terms
   // ----------------------------------------
   always_comb begin
      logic acc;
      acc  = 1'b1;
      term = '0;
      for (int i = 0; i < N_CH; i++) begin
         acc = acc & slice_hit[i];
         if (endpoint[i]) begin
            term[i] = acc;
            acc     = 1'b1;
         end
      end
   end

   assign any_match = |term;
   assign next_irq  = pm_on ? term : pin_req;
   assign cfg_clear = WR && (ADDR == REG_PM_CFG || ADDR == REG_PM_SRC);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         sel_lo     <= RST_WORD;
         sel_hi     <= RST_WORD;
         mode_level <= RST_CH;
         en_rise    <= RST_CH;
         en_fall    <= RST_CH;
         pm_on      <= 1'b0;
         ev_en      <= 1'b0;
         pm_src     <= RST_SRC;
         endpoint   <= LAST_ENDPOINT;
         pm_cond    <= RST_COND;
         wake_en    <= RST_CH;
      end else if (WR) begin
         case (ADDR)
            REG_SEL_LO:  sel_lo     <= WDATA;
            REG_SEL_HI:  sel_hi     <= WDATA;
            REG_MODE:    mode_level <= WDATA[N_CH-1:0];
            REG_EN_RISE: en_rise    <= WDATA[N_CH-1:0];
            REG_EN_FALL: en_fall    <= WDATA[N_CH-1:0];
            REG_PM_CTRL: begin
               pm_on <= WDATA[PM_CTRL_MODE_BIT];
               ev_en <= WDATA[PM_CTRL_EV_BIT];
            end
            REG_PM_SRC:  pm_src <= WDATA[N_CH*SRC_W-1:0];
            REG_PM_CFG: begin
               endpoint <= WDATA[N_CH-1:0] | LAST_ENDPOINT;
               pm_cond  <= WDATA[PM_CFG_COND_LSB +: N_CH*COND_W];
            end
            REG_WAKE_EN: wake_en <= WDATA[N_CH-1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // sticky edge status, write one to clear
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         rise_st <= RST_CH;
         fall_st <= RST_CH;
      end else begin
         rise_st <= (rise_st & ~((WR && ADDR == REG_RISE_ST) ? WDATA[N_CH-1:0] : RST_CH))
                  | (rise & en_rise & ~mode_level);
         fall_st <= (fall_st & ~((WR && ADDR == REG_FALL_ST) ? WDATA[N_CH-1:0] : RST_CH))
                  | (fall & en_fall & ~mode_level);
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      next_rdata = RST_WORD;
      case (ADDR)
         REG_SEL_LO:  next_rdata = sel_lo;
         REG_SEL_HI:  next_rdata = sel_hi;
         REG_MODE:    next_rdata[N_CH-1:0] = mode_level;
         REG_EN_RISE: next_rdata[N_CH-1:0] = en_rise;
         REG_EN_FALL: next_rdata[N_CH-1:0] = en_fall;
         REG_RISE_ST: next_rdata[N_CH-1:0] = rise_st;
         REG_FALL_ST: next_rdata[N_CH-1:0] = fall_st;
         REG_STATUS:  next_rdata[N_CH-1:0] = IRQ;
         REG_PM_CTRL: begin
            next_rdata[PM_CTRL_MODE_BIT] = pm_on;
            next_rdata[PM_CTRL_EV_BIT]   = ev_en;
            next_rdata[PM_CTRL_TERM_LSB +: N_CH] = term;
         end
         REG_PM_SRC:  next_rdata[N_CH*SRC_W-1:0] = pm_src;
         REG_PM_CFG: begin
            next_rdata[N_CH-1:0] = endpoint;
            next_rdata[PM_CFG_COND_LSB +: N_CH*COND_W] = pm_cond;
         end
         REG_WAKE_EN: next_rdata[N_CH-1:0] = wake_en;
         default:     next_rdata = RST_WORD;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= RST_WORD;
      end else begin
         RDATA <= RD ? next_rdata : RST_WORD;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ <= RST_CH;
      end else begin
         IRQ <= next_irq;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         WAKE_REQ <= 1'b0;
      end else begin
         WAKE_REQ <= |(next_irq & wake_en);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         match_prev            <= 1'b0;
         CPU_EVENT_NOTIFY      <= 1'b0;
         PATTERN_MATCH_PIN_OUT <= 1'b0;
      end else begin
         match_prev            <= pm_on & any_match;
         CPU_EVENT_NOTIFY      <= ev_en & pm_on & any_match & ~match_prev;
         PATTERN_MATCH_PIN_OUT <= pm_on & any_match;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   rdata_idle_a: assert property (!RD |=> RDATA == RST_WORD)
      else $error("read data not zero outside a read");

   sel_write_a: assert property (WR && ADDR == REG_SEL_LO |=> sel_lo == $past(WDATA))
      else $error("pin select write not taken in one cycle");

   rise_sticky_a: assert property (
      1'b1 |=> ((rise_st & $past(rise & en_rise & ~mode_level))
               == $past(rise & en_rise & ~mode_level)))
      else $error("enabled rising edge not latched");

   fall_sticky_a: assert property (
      1'b1 |=> ((fall_st & $past(fall & en_fall & ~mode_level))
               == $past(fall & en_fall & ~mode_level)))
      else $error("enabled falling edge not latched");

   irq_source_a: assert property (
      !pm_on && $stable(pm_on) |=> IRQ == $past(pin_req))
      else $error("pin request not on its own line");

   level_irq_a: assert property (
      !pm_on |=> (IRQ & $past(mode_level)) == $past(mode_level & en_rise & (lvl ~^ en_fall)))
      else $error("level request missing");

   term_irq_a: assert property (pm_on |=> IRQ == $past(term))
      else $error("product term request wrong");

   term_only_a: assert property (pm_on |=> (IRQ & ~$past(endpoint)) == '0)
      else $error("request on a slice that ends no term");

   event_pulse_a: assert property (CPU_EVENT_NOTIFY |=> !CPU_EVENT_NOTIFY)
      else $error("event not a single pulse");

   event_cause_a: assert property (
      CPU_EVENT_NOTIFY |-> $past(ev_en && pm_on && any_match) && PATTERN_MATCH_PIN_OUT)
      else $error("event without enabled match");

   pattern_pin_a: assert property (
      $past(pm_on && any_match) |-> PATTERN_MATCH_PIN_OUT)
      else $error("match not on pattern output");

   wake_req_a: assert property (|(IRQ & wake_en) && $stable(wake_en) |-> WAKE_REQ)
      else $error("wake not raised by request");

   edge_detect_a: assert property (
      !$past(RST, 2) && lvl[0] && !$past(lvl[0]) |-> rise[0] && !fall[0])
      else $error("rising edge not seen");
endmodule

// ==== rtl/pin_sync_edge.sv ====
// two-stage synchroniser with edge detection for one selected pin
`timescale 1ns/100ps
module pin_sync_edge (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic pin,
   output logic      lvl,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic sync;
   logic prev;
   logic meta_ok;
   logic sync_ok;
   logic prev_ok;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   // ----------------------------------------
   // warm-up: no edge until prev holds a live sample
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         meta_ok <= 1'b0;
         sync_ok <= 1'b0;
         prev_ok <= 1'b0;
      end else begin
         meta_ok <= 1'b1;
         sync_ok <= meta_ok;
         prev_ok <= sync_ok;
      end
   end

   // compare current sample with the previous one
   assign lvl  = sync;
   assign rise = sync & ~prev & prev_ok;
   assign fall = ~sync & prev & prev_ok;
endmodule

// ==== rtl/pint_pkg.sv ====
// constants, register map and encodings for the pin interrupt and pattern engine
package pint_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int N_CH    = 8;
   localparam int N_PINS  = 32;
   localparam int SEL_W   = 5;
   localparam int SRC_W   = 3;
   localparam int COND_W  = 3;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int SEL_STRIDE = 8;
   localparam int SEL_PER_REG = 4;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] REG_SEL_LO  = 8'h00;
   localparam logic [ADDR_W-1:0] REG_SEL_HI  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_MODE    = 8'h08;
   localparam logic [ADDR_W-1:0] REG_EN_RISE = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_EN_FALL = 8'h10;
   localparam logic [ADDR_W-1:0] REG_RISE_ST = 8'h14;
   localparam logic [ADDR_W-1:0] REG_FALL_ST = 8'h18;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_PM_CTRL = 8'h20;
   localparam logic [ADDR_W-1:0] REG_PM_SRC  = 8'h24;
   localparam logic [ADDR_W-1:0] REG_PM_CFG  = 8'h28;
   localparam logic [ADDR_W-1:0] REG_WAKE_EN = 8'h2c;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PM_CTRL_MODE_BIT = 0;
   localparam int PM_CTRL_EV_BIT   = 1;
   localparam int PM_CTRL_TERM_LSB = 8;
   localparam int PM_CFG_COND_LSB  = 8;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [DATA_W-1:0]         RST_WORD = 32'h0000_0000;
   localparam logic [N_CH-1:0]           RST_CH   = 8'h00;
   localparam logic [N_CH*SRC_W-1:0]     RST_SRC  = 24'hfac688;
   localparam logic [N_CH*COND_W-1:0]    RST_COND = 24'h000000;
   localparam logic [N_CH-1:0]           LAST_ENDPOINT = 8'h80;

   // ----------------------------------------
   // slice conditions
   // ----------------------------------------
   typedef enum logic [COND_W-1:0] {
      COND_ALWAYS    = 3'h0,
      COND_RISE_ST   = 3'h1,
      COND_FALL_ST   = 3'h2,
      COND_EDGE_ST   = 3'h3,
      COND_HIGH      = 3'h4,
      COND_LOW       = 3'h5,
      COND_NEVER     = 3'h6,
      COND_EDGE_NOW  = 3'h7
   } cond_t;
endpackage

// ==== test/irq_ctrl_model.sv ====
// far-side model: interrupt controller request lines and cpu event input
`timescale 1ns/100ps
module irq_ctrl_model
   import pint_pkg::*;
(
   input  wire logic            CLK,
   input  wire logic            RST,
   input  wire logic [N_CH-1:0] irq,
   input  wire logic            evt,
   output logic      [N_CH-1:0] pend,
   output int                   ev_count
);
   // ----------------------------------------
   // one pending flag per request line
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         pend <= '0;
      end else begin
         pend <= pend | irq;
      end
   end

   // ----------------------------------------
   // event input: every cycle high counts
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         ev_count <= 0;
      end else if (evt === 1'b1) begin
         ev_count <= ev_count + 1;
      end
   end
endmodule

// ==== test/pin_interrupt_pattern_match_test.sv ====
// self-checking testbench for the pin interrupt and pattern engine
`timescale 1ns/100ps
module pin_interrupt_pattern_match_test;
   import pint_pkg::*;
   logic              CLK   = 1'b0;
   logic              RST   = 1'b1;
   logic [N_PINS-1:0] PINS  = '0;
   logic [ADDR_W-1:0] ADDR  = '0;
   logic [DATA_W-1:0] WDATA = '0;
   logic              WR    = 1'b0;
   logic              RD    = 1'b0;
   logic [DATA_W-1:0] RDATA;
   logic [N_CH-1:0]   IRQ;
   logic              WAKE_REQ;
   logic              CPU_EVENT_NOTIFY;
   logic              PATTERN_MATCH_PIN_OUT;
   logic [N_CH-1:0]   pend;
   int                ev_count;
   int                num_errors = 0;
   int                num_checks = 0;

   always #10 CLK = ~CLK;

   pin_interrupt_pattern_match uut (.CLK(CLK), .RST(RST), .PINS(PINS), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ),
      .CPU_EVENT_NOTIFY(CPU_EVENT_NOTIFY), .PATTERN_MATCH_PIN_OUT(PATTERN_MATCH_PIN_OUT));
   irq_ctrl_model partner (.CLK(CLK), .RST(RST), .irq(IRQ), .evt(CPU_EVENT_NOTIFY),
      .pend(pend), .ev_count(ev_count));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge CLK);
      WR    <= 1'b1;
      ADDR  <= a;
      WDATA <= d;
      @(posedge CLK);
      WR    <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
      @(posedge CLK);
      RD   <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD   <= 1'b0;
      #1;
      chk(name, exp, RDATA);
      @(posedge CLK);
      #1;
      chk({name, " after"}, 32'h0, RDATA);
   endtask

   task automatic pin(input int i, input logic v);
      @(posedge CLK);
      PINS[i] <= v;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("irq after reset", 32'h0, {24'h0, IRQ});
      rd_chk("slice sources", REG_PM_SRC, {8'h00, RST_SRC});
      rd_chk("slice config", REG_PM_CFG, {RST_COND, LAST_ENDPOINT});
      rd_chk("unmapped read", 8'h30, 32'h0);
   endtask

   task automatic t_edge;
      wr(REG_SEL_LO, 32'h0000_0003);
      wr(REG_SEL_HI, 32'h1f00_0000);
      wr(REG_EN_RISE, 32'h0000_0081);
      wr(REG_EN_FALL, 32'h0000_0080);
      pin(3, 1'b1);
      pin(31, 1'b1);
      idle(6);
      chk("rise irq", 32'h81, {24'h0, IRQ});
      wr(REG_RISE_ST, 32'h0000_0081);
      pin(3, 1'b0);
      pin(31, 1'b0);
      idle(6);
      chk("fall irq", 32'h80, {24'h0, IRQ});
      rd_chk("status", REG_STATUS, 32'h0000_0080);
      wr(REG_FALL_ST, 32'h0000_0080);
      idle(2);
      chk("cleared irq", 32'h0, {24'h0, IRQ});
   endtask

   task automatic t_level;
      wr(REG_SEL_LO, 32'h0605_0003);
      wr(REG_MODE, 32'h0000_000c);
      wr(REG_EN_RISE, 32'h0000_000c);
      wr(REG_EN_FALL, 32'h0000_0004);
      wr(REG_WAKE_EN, 32'h0000_0008);
      idle(6);
      chk("low active irq", 32'h08, {24'h0, IRQ});
      chk("wake set", 32'h1, {31'h0, WAKE_REQ});
      pin(5, 1'b1);
      pin(6, 1'b1);
      idle(6);
      chk("high active irq", 32'h04, {24'h0, IRQ});
      chk("wake clear", 32'h0, {31'h0, WAKE_REQ});
      rd_chk("no sticky", REG_RISE_ST, 32'h0);
   endtask

   task automatic t_pattern;
      int ev0;
      ev0 = ev_count;
      wr(REG_PM_CFG, 32'hdb6d_ac02);
      wr(REG_PM_CTRL, 32'h0000_0003);
      rd_chk("endpoint forced", REG_PM_CFG, 32'hdb6d_ac82);
      pin(3, 1'b1);
      idle(6);
      chk("term irq", 32'h02, {24'h0, IRQ});
      chk("match out", 32'h1, {31'h0, PATTERN_MATCH_PIN_OUT});
      chk("event pulse", 32'h1, ev_count - ev0);
      pin(0, 1'b1);
      idle(6);
      chk("term off", 32'h0, {24'h0, IRQ});
      wr(REG_PM_CTRL, 32'h0000_0001);
      pin(0, 1'b0);
      idle(6);
      chk("match again", 32'h1, {31'h0, PATTERN_MATCH_PIN_OUT});
      chk("event masked", 32'h1, ev_count - ev0);
      pin(3, 1'b0);
      wr(REG_PM_CFG, 32'hdb6d_a902);
      idle(6);
      chk("no edge yet", 32'h0, {31'h0, PATTERN_MATCH_PIN_OUT});
      pin(3, 1'b1);
      pin(3, 1'b0);
      idle(6);
      chk("sticky rise", 32'h1, {31'h0, PATTERN_MATCH_PIN_OUT});
      chk("partner saw term", 32'h1, {31'h0, pend[1]});
   endtask

   task automatic t_source;
      int ev1;
      wr(REG_PM_SRC, 32'h00fa_c697);
      wr(REG_PM_CFG, 32'h6000_2203);
      idle(2);
      chk("rerouted term", 32'h02, {24'h0, IRQ});
      rd_chk("new sources", REG_PM_SRC, 32'h00fa_c697);
      pin(31, 1'b1);
      idle(6);
      chk("edge sticky term", 32'h82, {24'h0, IRQ});
      pin(31, 1'b0);
      idle(6);
      chk("fall sticky term", 32'h83, {24'h0, IRQ});
      rd_chk("live terms", REG_PM_CTRL, 32'h0000_8301);
      wr(REG_PM_CTRL, 32'h0000_0003);
      wr(REG_PM_CFG, 32'hdb6d_b701);
      ev1 = ev_count;
      pin(31, 1'b1);
      idle(6);
      chk("edge now event", 32'h1, ev_count - ev1);
      chk("edge now gone", 32'h0, {24'h0, IRQ});
      chk("edge now out", 32'h0, {31'h0, PATTERN_MATCH_PIN_OUT});
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      idle(1);
      t_reset;
      t_edge;
      t_level;
      t_pattern;
      t_source;
      wrap_up;
   end

   initial begin
      #400000;
      num_errors++;
      wrap_up;
   end
endmodule
